// *** tb/pll_output_and_control_test.sv ***
`timescale 1ns/100ps
module pll_output_and_control_test;
   logic       core_clk, rst, refClkPin, pllEnable, pllAreset, pfdEnable;
   logic [1:0] compModeSel;
   logic       compOutSel, extOutUsed, extDiffMode, refRun, farLevel;
   logic [2:0] fbTap, globalADivTap, globalBDivTap, extDivTap;
   logic [4:0] preDivM1, mulDivM1, globalADivHighM1, globalADivLowM1, globalADivInit;
   logic [4:0] globalBDivHighM1, globalBDivLowM1, globalBDivInit;
   logic [4:0] extDivHighM1, extDivLowM1, extDivInit;
   logic       gpioPOut, gpioPOe, gpioNOut, gpioNOe, padPIn, padNIn;
   logic       globalClkA, globalClkB, extPinPOut, extPinPOe, extPinNOut, extPinNOe;
   logic       gpioPIn, gpioNIn, pllLocked;
   int         miscompares, nCompared, n, h, l;

   poc_pll_core poc_pll_core_i (.*);
   poc_far_end poc_far_end_i (.*);

   always #20 core_clk = ~core_clk;

   task automatic step(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : step

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      nCompared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic pick(input int s);
      return s == 0 ? globalClkA : s == 1 ? globalClkB : extPinPOut;
   endfunction : pick

   task automatic waitRise(input int s, output int k);
      logic p;
      k = 0;
      p = pick(s);
      step(1);
      while (!(p === 1'b0 && pick(s) === 1'b1) && k < 200) begin
         p = pick(s);
         step(1);
         k++;
      end
   endtask : waitRise

   task automatic runLen(input int s, output int k);
      logic v;
      v = pick(s);
      k = 0;
      while (pick(s) === v && k < 300) begin
         step(1);
         k++;
      end
   endtask : runLen

   task automatic waitLock();
      int i;
      int ok;
      ok = 0;
      // raw lock may chatter while pulling in, so demand a steady run
      for (i = 0; i < 1500 && ok < 64; i++) begin
         ok = pllLocked === 1'b1 ? ok + 1 : 0;
         step(1);
      end
      chk(16'(ok), 16'h0040);
   endtask : waitLock

   task automatic t_taps();
      waitLock();
      waitRise(0, n);
      waitRise(1, n);
      chk(16'(n + 1), 16'h0003);
      waitRise(0, n);
      waitRise(2, n);
      chk(16'(n + 1), 16'h0009);
      waitRise(0, n);
      runLen(0, h);
      runLen(0, l);
      chk({8'(h), 8'(l)}, 16'h0808);
      chk({extPinPOe, extPinNOe, extPinNOut ^ extPinPOut}, 16'h0007);
      $display("t_taps done");
   endtask : t_taps

   task automatic t_enable();
      pllEnable = 1'b0;
      step(4);
      chk({globalClkA, globalClkB, pllLocked}, 16'h0000);
      step(40);
      chk({globalClkA, globalClkB, pllLocked}, 16'h0000);
      globalBDivHighM1 = 5'h02;
      fbTap = 3'h5;
      pllEnable = 1'b1;
      waitLock();
      waitRise(1, n);
      runLen(1, h);
      runLen(1, l);
      chk(16'(h), 16'h0018);
      chk(16'(l), 16'h0008);
      waitRise(1, n);
      waitRise(0, n);
      // b now ticks on phase 0 and a on phase 5, both shifted alike
      chk(16'(n + 1), 16'h0005);
      $display("t_enable done");
   endtask : t_enable

   task automatic t_areset();
      pllAreset = 1'b1;
      step(4);
      chk({globalClkA, globalClkB, pllLocked}, 16'h0000);
      step(20);
      chk({globalClkA, globalClkB, pllLocked}, 16'h0000);
      pllAreset = 1'b0;
      waitLock();
      $display("t_areset done");
   endtask : t_areset

   task automatic t_modes();
      int m;
      for (m = 0; m < 4; m++) begin
         pllEnable = 1'b0;
         step(4);
         compModeSel = 2'(m);
         pllEnable = 1'b1;
         waitLock();
         chk({15'h0000, pllLocked}, 16'h0001);
      end
      $display("t_modes done");
   endtask : t_modes

   task automatic t_gate();
      int i;
      int c;
      logic p;
      c = 0;
      pfdEnable = 1'b0;
      refRun = 1'b0;
      step(40);
      p = globalClkA;
      for (i = 0; i < 64; i++) begin
         step(1);
         c += (p === 1'b0 && globalClkA === 1'b1) ? 1 : 0;
         p = globalClkA;
      end
      chk(16'(c), 16'h0004);
      refRun = 1'b1;
      pfdEnable = 1'b1;
      waitLock();
      $display("t_gate done");
   endtask : t_gate

   task automatic t_pads();
      extOutUsed = 1'b0;
      {gpioPOut, gpioPOe, gpioNOe} = 3'h6;
      step(4);
      chk({extPinPOe, extPinPOut, gpioPIn, extPinNOe, gpioNIn}, 16'h001D);
      gpioPOe = 1'b0;
      step(4);
      chk({extPinPOe, gpioPIn, gpioNIn}, 16'h0001);
      $display("t_pads done");
   endtask : t_pads

   task automatic end_sim();
      $display("compared %0d mismatches %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (30000) @(posedge core_clk);
      miscompares++;
      end_sim();
   end

   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      miscompares = 0;
      nCompared = 0;
      {pllEnable, pllAreset, pfdEnable, refRun} = 4'hB;
      {extOutUsed, extDiffMode, compOutSel, farLevel} = 4'hC;
      {gpioPOut, gpioPOe, gpioNOut, gpioNOe} = 4'h0;
      {compModeSel, fbTap, globalADivTap, globalBDivTap, extDivTap} = 14'h0018;
      {preDivM1, mulDivM1} = 10'h001;
      {globalADivHighM1, globalADivLowM1, globalADivInit} = 15'h0000;
      {globalBDivHighM1, globalBDivLowM1, globalBDivInit} = 15'h0000;
      {extDivHighM1, extDivLowM1, extDivInit} = 15'h0001;
      step(4);
      rst = 1'b0;
      t_taps();
      t_enable();
      t_areset();
      t_modes();
      t_gate();
      t_pads();
      end_sim();
   end
endmodule : pll_output_and_control_test

// *** tb/poc_far_end.sv ***
`timescale 1ns/100ps
module poc_far_end #(
   parameter int HALF_NS = 320
) (
   input  wire logic refRun,
   input  wire logic farLevel,
   input  wire logic extPinPOut,
   input  wire logic extPinPOe,
   input  wire logic extPinNOut,
   input  wire logic extPinNOe,
   output logic      refClkPin,
   output logic      padPIn,
   output logic      padNIn
);
   // reference from a pin, period 16 core cycles, not edge aligned
   initial refClkPin = 1'b0;
   always #(HALF_NS) refClkPin = refRun ? ~refClkPin : 1'b0;
   // undriven pads show the far device, never a stale value
   assign padPIn = extPinPOe ? extPinPOut : farLevel;
   assign padNIn = extPinNOe ? extPinNOut : ~farLevel;
endmodule : poc_far_end

// *** tb/poc_pll_core_properties.sv ***
`timescale 1ns/100ps
module poc_pll_core_properties (
   input wire logic                      core_clk,
   input wire logic                      rst,
   input wire logic                      pllEnable,
   input wire logic                      pllAreset,
   input wire logic                      extOutUsed,
   input wire logic                      extDiffMode,
   input wire logic                      gpioPOe,
   input wire logic                      padPIn,
   input wire logic [poc_pkg::DIV_W-1:0] globalADivHighM1,
   input wire logic [poc_pkg::DIV_W-1:0] globalADivLowM1,
   input wire logic                      globalClkA,
   input wire logic                      globalClkB,
   input wire logic                      extPinPOut,
   input wire logic                      extPinPOe,
   input wire logic                      extPinNOut,
   input wire logic                      extPinNOe,
   input wire logic                      gpioPIn,
   input wire logic                      pllLocked
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // four samples leave room for the two-stage pin sync
   en_off_zero_a: assert property (
      !pllEnable [*4] |=> !globalClkA && !globalClkB && !pllLocked)
      else $error("outputs alive while disabled");
   arst_clear_a: assert property (
      pllAreset [*4] |=> !globalClkA && !globalClkB && !pllLocked)
      else $error("outputs alive while held in reset");
   diff_pair_a: assert property (
      !$past(rst) && $past(extOutUsed && extDiffMode) && extOutUsed && extDiffMode
      |-> extPinNOut != extPinPOut)
      else $error("differential pads not complementary");
   ext_drive_a: assert property (
      !$past(rst) && $past(extOutUsed && extDiffMode) && extOutUsed && extDiffMode
      |-> extPinPOe && extPinNOe)
      else $error("owned pads not driven");
   pad_free_a: assert property (
      !$past(rst) && $past(!extOutUsed) && !extOutUsed && $stable(gpioPOe)
      |-> extPinPOe == gpioPOe)
      else $error("released pad enable not from user");
   pad_sync_a: assert property (
      !$past(rst) && !$past(rst, 2) |-> gpioPIn == $past(padPIn, 2))
      else $error("pad input not two stages behind pad");
   // a slip drops lock, which aborts the attempt, so the time is exact
   duty_high_a: assert property (disable iff (rst || !pllEnable || pllAreset || !pllLocked)
      $rose(globalClkA) && pllLocked && globalADivHighM1 == 5'h00
      |-> globalClkA [*8] ##1 !globalClkA)
      else $error("high time differs from count");
   duty_low_a: assert property (disable iff (rst || !pllEnable || pllAreset || !pllLocked)
      $fell(globalClkA) && pllLocked && globalADivLowM1 == 5'h00
      |-> !globalClkA [*8] ##1 globalClkA)
      else $error("low time differs from count");

   cover property ($rose(pllLocked));
   cover property ($fell(pllLocked));
   cover property ($rose(globalClkB));
endmodule : poc_pll_core_properties

bind poc_pll_core poc_pll_core_properties poc_pll_core_properties_i (.*);

// *** verilog/poc_pkg.sv ***
package poc_pkg;
   // eight vco taps, one core_clk cycle per tap
   localparam int TAP_W    = 3;
   localparam int DIV_W    = 5;
   localparam int NUM_POST = 3;
   localparam int IDX_GA   = 0;
   localparam int IDX_GB   = 1;
   localparam int IDX_EXT  = 2;

   // bit positions inside the input synchroniser
   localparam int S_REF  = 0;
   localparam int S_EN   = 1;
   localparam int S_ARST = 2;
   localparam int S_PFD  = 3;
   localparam int S_PADP = 4;
   localparam int S_PADN = 5;
   localparam int SYNC_W = 6;

   // compensation mode select codes
   localparam logic [1:0] COMP_CODE_NONE   = 2'h0;
   localparam logic [1:0] COMP_CODE_NORMAL = 2'h1;
   localparam logic [1:0] COMP_CODE_ZDB    = 2'h2;

   // dividers hold value minus one; multiply counter floor is 2
   localparam logic [DIV_W-1:0] MUL_MIN_M1 = 5'h01;

   // clock network and pin delays that the feedback compensates
   localparam int CORE_PERIOD_PS = 40000;
   localparam int NET_DLY_PS     = 160000;
   localparam int NET_DLY_CYC    = (NET_DLY_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
   localparam int PIN_DLY_CYC    = 1;
   localparam int DLY_W          = 4;
   localparam logic [DLY_W-1:0] NET_DLY_LOAD = DLY_W'(NET_DLY_CYC);
   localparam logic [DLY_W-1:0] PIN_DLY_LOAD = DLY_W'(PIN_DLY_CYC);
   localparam logic [DLY_W-1:0] DLY_FIRE     = 4'h1;

   // lock detector
   localparam int AGE_W = 6;
   localparam logic [AGE_W-1:0] LOCK_WIN   = 6'h02;
   localparam logic [2:0]       LOCK_LAST  = 3'h3;
   localparam logic [2:0]       MATCH_INIT = 3'h0;

   typedef enum logic [2:0] {
      LK_OFF  = 3'b001,
      LK_ACQ  = 3'b010,
      LK_HOLD = 3'b100
   } poc_lock_t;

   typedef enum logic [2:0] {
      CM_NONE   = 3'b001,
      CM_NORMAL = 3'b010,
      CM_ZDB    = 3'b100
   } poc_comp_t;
endpackage : poc_pkg

// *** verilog/poc_pll_core.sv ***
`timescale 1ns/100ps
// Behaviour
// - one external clock output, pair or single
// - unused external clock pins become general I/O
// - zero-delay mode aligns external output to input
// - normal mode compensates one selected global output
// - no-compensation mode compensates no clock network
// - phase step is one eighth vco period
// - each output counter picks its own tap
// - initial post count extends shift over period
// - feedback tap shifts all outputs together
// - lock asserts when output tracks reference phase
// - post counters set duty by high/low counts
// - enable low: outputs zero, out of lock
// - enable high again: relock and resynchronize
// - reset high: counters to start values (post: initial count), clear outputs, lock
// - reset released: resynchronize while relocking
// - detector gated: vco holds, outputs keep running
// - dividers 1..32, multiply counter 2..32
module poc_pll_core (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire logic                       refClkPin,
   input  wire logic                       pllEnable,
   input  wire logic                       pllAreset,
   input  wire logic                       pfdEnable,
   input  wire logic [1:0]                 compModeSel,
   input  wire logic                       compOutSel,
   input  wire logic [poc_pkg::TAP_W-1:0]  fbTap,
   input  wire logic [poc_pkg::DIV_W-1:0]  preDivM1,
   input  wire logic [poc_pkg::DIV_W-1:0]  mulDivM1,
   input  wire logic [poc_pkg::DIV_W-1:0]  globalADivHighM1,
   input  wire logic [poc_pkg::DIV_W-1:0]  globalADivLowM1,
   input  wire logic [poc_pkg::TAP_W-1:0]  globalADivTap,
   input  wire logic [poc_pkg::DIV_W-1:0]  globalADivInit,
   input  wire logic [poc_pkg::DIV_W-1:0]  globalBDivHighM1,
   input  wire logic [poc_pkg::DIV_W-1:0]  globalBDivLowM1,
   input  wire logic [poc_pkg::TAP_W-1:0]  globalBDivTap,
   input  wire logic [poc_pkg::DIV_W-1:0]  globalBDivInit,
   input  wire logic [poc_pkg::DIV_W-1:0]  extDivHighM1,
   input  wire logic [poc_pkg::DIV_W-1:0]  extDivLowM1,
   input  wire logic [poc_pkg::TAP_W-1:0]  extDivTap,
   input  wire logic [poc_pkg::DIV_W-1:0]  extDivInit,
   input  wire logic                       extOutUsed,
   input  wire logic                       extDiffMode,
   input  wire logic                       gpioPOut,
   input  wire logic                       gpioPOe,
   input  wire logic                       gpioNOut,
   input  wire logic                       gpioNOe,
   input  wire logic                       padPIn,
   input  wire logic                       padNIn,
   output logic                            globalClkA,
   output logic                            globalClkB,
   output logic                            extPinPOut,
   output logic                            extPinPOe,
   output logic                            extPinNOut,
   output logic                            extPinNOe,
   output logic                            gpioPIn,
   output logic                            gpioNIn,
   output logic                            pllLocked
);
   localparam int TW = poc_pkg::TAP_W;
   localparam int DW = poc_pkg::DIV_W;
   localparam int NP = poc_pkg::NUM_POST;

   function automatic poc_pkg::poc_comp_t decodeComp(input logic [1:0] code);
      case (code)
         poc_pkg::COMP_CODE_NORMAL: decodeComp = poc_pkg::CM_NORMAL;
         poc_pkg::COMP_CODE_ZDB:    decodeComp = poc_pkg::CM_ZDB;
         default:                   decodeComp = poc_pkg::CM_NONE;
      endcase
   endfunction : decodeComp

   function automatic logic [TW-1:0] tapAdd(input logic [TW-1:0] a, input logic [TW-1:0] b);
      logic [TW:0] s;
      s = {1'b0, a} + {1'b0, b};
      tapAdd = s[TW-1:0];
   endfunction : tapAdd

   logic [poc_pkg::SYNC_W-1:0] meta_ff;
   logic [poc_pkg::SYNC_W-1:0] sync_ff;
   logic                       refPrev_ff;
   logic                       refRise;
   logic                       run;
   logic                       active;
   logic                       pfdOn;
   logic                       needSync_ff;
   logic [DW-1:0]              nCnt_ff;
   logic                       refEvt;
   logic                       slipReq_ff;
   logic                       stepOn;
   logic [TW-1:0]              vcoPhase_ff;
   logic [DW-1:0]              mCnt_ff;
   logic [DW-1:0]              mulLoad;
   logic                       mTick;
   logic                       mWrap;
   logic [DW-1:0]              highM1   [NP];
   logic [DW-1:0]              lowM1    [NP];
   logic [DW-1:0]              initCnt  [NP];
   logic [TW-1:0]              tapSel   [NP];
   logic [DW-1:0]              postCnt_ff [NP];
   logic                       postLvl_ff [NP];
   logic [NP-1:0]              postTick;
   logic [NP-1:0]              postRise;
   poc_pkg::poc_comp_t         compMode;
   logic                       srcRise;
   logic [poc_pkg::DLY_W-1:0]  dlyLoad;
   logic [poc_pkg::DLY_W-1:0]  dlyCnt_ff;
   logic                       fbEvt;
   logic [poc_pkg::AGE_W-1:0]  fbAge_ff;
   logic                       match;
   logic [2:0]                 matchCnt_ff;
   poc_pkg::poc_lock_t         lockState_ff;
   poc_pkg::poc_lock_t         nxt_lockState;
   logic                       diffOn;
   logic                       pinPOut_ff;
   logic                       pinPOe_ff;
   logic                       pinNOut_ff;
   logic                       pinNOe_ff;

   // pins and array logic alike may drive these, so all are synchronised
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= {padNIn, padPIn, pfdEnable, pllAreset, pllEnable, refClkPin};
         sync_ff <= meta_ff;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         refPrev_ff <= 1'b0;
      end else begin
         refPrev_ff <= sync_ff[poc_pkg::S_REF];
      end
   end

   assign refRise = sync_ff[poc_pkg::S_REF] & ~refPrev_ff;
   assign run     = sync_ff[poc_pkg::S_EN] & ~sync_ff[poc_pkg::S_ARST];
   assign pfdOn   = sync_ff[poc_pkg::S_PFD];
   assign active  = run & ~needSync_ff;

   // pre-scale divider on reference edges
   always_ff @(posedge core_clk) begin
      if (rst || !run) begin
         nCnt_ff <= '0;
      end else if (refRise) begin
         nCnt_ff <= (nCnt_ff == '0) ? preDivM1 : nCnt_ff - 1'b1;
      end
   end

   assign refEvt = run & refRise & (nCnt_ff == '0);

   // counters wait for the first divided reference edge after start
   always_ff @(posedge core_clk) begin
      if (rst || !run) begin
         needSync_ff <= 1'b1;
      end else if (refEvt) begin
         needSync_ff <= 1'b0;
      end
   end

   // phase detector: a late feedback edge holds the vco one tap
   always_ff @(posedge core_clk) begin
      if (rst || !active) begin
         slipReq_ff <= 1'b0;
      end else begin
         slipReq_ff <= refEvt & pfdOn & ~match;
      end
   end

   assign stepOn = active & ~slipReq_ff;

   // one core_clk per tap, so a step is an eighth of the vco period
   always_ff @(posedge core_clk) begin
      if (rst || !active) begin
         vcoPhase_ff <= '0;
      end else if (stepOn) begin
         vcoPhase_ff <= vcoPhase_ff + 1'b1;
      end
   end

   // multiply counter below 2 is clamped rather than refused
   assign mulLoad = (mulDivM1 < poc_pkg::MUL_MIN_M1) ? poc_pkg::MUL_MIN_M1 : mulDivM1;
   assign mTick   = stepOn & (vcoPhase_ff == fbTap);
   assign mWrap   = mTick & (mCnt_ff == '0);

   always_ff @(posedge core_clk) begin
      if (rst || !active) begin
         mCnt_ff <= '0;
      end else if (mTick) begin
         mCnt_ff <= (mCnt_ff == '0) ? mulLoad : mCnt_ff - 1'b1;
      end
   end

   always_comb begin
      highM1[poc_pkg::IDX_GA]  = globalADivHighM1;
      lowM1[poc_pkg::IDX_GA]   = globalADivLowM1;
      initCnt[poc_pkg::IDX_GA] = globalADivInit;
      tapSel[poc_pkg::IDX_GA]  = globalADivTap;
      highM1[poc_pkg::IDX_GB]  = globalBDivHighM1;
      lowM1[poc_pkg::IDX_GB]   = globalBDivLowM1;
      initCnt[poc_pkg::IDX_GB] = globalBDivInit;
      tapSel[poc_pkg::IDX_GB]  = globalBDivTap;
      highM1[poc_pkg::IDX_EXT]  = extDivHighM1;
      lowM1[poc_pkg::IDX_EXT]   = extDivLowM1;
      initCnt[poc_pkg::IDX_EXT] = extDivInit;
      tapSel[poc_pkg::IDX_EXT]  = extDivTap;
   end

   always_comb begin
      for (int i = 0; i < NP; i++) begin
         postTick[i] = stepOn & (vcoPhase_ff == tapAdd(tapSel[i], fbTap));
         postRise[i] = postTick[i] & (postCnt_ff[i] == '0) & ~postLvl_ff[i];
      end
   end

   // post-scale counters: initial count delays the first rise
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < NP; i++) begin
         if (rst) begin
            postCnt_ff[i] <= '0;
            postLvl_ff[i] <= 1'b0;
         end else if (!active) begin
            postCnt_ff[i] <= initCnt[i];
            postLvl_ff[i] <= 1'b0;
         end else if (postTick[i]) begin
            if (postCnt_ff[i] == '0) begin
               postLvl_ff[i] <= ~postLvl_ff[i];
               postCnt_ff[i] <= postLvl_ff[i] ? lowM1[i] : highM1[i];
            end else begin
               postCnt_ff[i] <= postCnt_ff[i] - 1'b1;
            end
         end
      end
   end

   assign compMode = decodeComp(compModeSel);

   // feedback source: external output, chosen global, or bare m counter
   always_comb begin
      if (compMode == poc_pkg::CM_ZDB) begin
         srcRise = postRise[poc_pkg::IDX_EXT];
         dlyLoad = poc_pkg::PIN_DLY_LOAD;
      end else begin
         srcRise = compOutSel ? postRise[poc_pkg::IDX_GB] : postRise[poc_pkg::IDX_GA];
         dlyLoad = poc_pkg::NET_DLY_LOAD;
      end
   end

   // delay copy of the source edge; a new edge restarts it
   always_ff @(posedge core_clk) begin
      if (rst || !active) begin
         dlyCnt_ff <= '0;
      end else if (srcRise) begin
         dlyCnt_ff <= dlyLoad;
      end else if (dlyCnt_ff != '0) begin
         dlyCnt_ff <= dlyCnt_ff - 1'b1;
      end
   end

   assign fbEvt = (compMode == poc_pkg::CM_NONE) ? mWrap : (dlyCnt_ff == poc_pkg::DLY_FIRE);

   always_ff @(posedge core_clk) begin
      if (rst || !active) begin
         fbAge_ff <= '1;
      end else if (fbEvt) begin
         fbAge_ff <= '0;
      end else if (fbAge_ff != '1) begin
         fbAge_ff <= fbAge_ff + 1'b1;
      end
   end

   assign match = fbEvt | (fbAge_ff <= poc_pkg::LOCK_WIN);

   always_ff @(posedge core_clk) begin
      if (rst || !active) begin
         matchCnt_ff <= poc_pkg::MATCH_INIT;
      end else if (refEvt && !match) begin
         matchCnt_ff <= poc_pkg::MATCH_INIT;
      end else if (refEvt && matchCnt_ff != poc_pkg::LOCK_LAST) begin
         matchCnt_ff <= matchCnt_ff + 1'b1;
      end
   end

   // lock is raw: a slipping loop may toggle it while acquiring
   always_comb begin
      nxt_lockState = lockState_ff;
      case (lockState_ff)
         poc_pkg::LK_OFF: begin
            if (active) begin
               nxt_lockState = poc_pkg::LK_ACQ;
            end
         end
         poc_pkg::LK_ACQ: begin
            if (refEvt && match && matchCnt_ff == poc_pkg::LOCK_LAST) begin
               nxt_lockState = poc_pkg::LK_HOLD;
            end
         end
         poc_pkg::LK_HOLD: begin
            if (refEvt && !match) begin
               nxt_lockState = poc_pkg::LK_ACQ;
            end
         end
         default: nxt_lockState = poc_pkg::LK_OFF;
      endcase
      if (!active) begin
         nxt_lockState = poc_pkg::LK_OFF;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         lockState_ff <= poc_pkg::LK_OFF;
      end else begin
         lockState_ff <= nxt_lockState;
      end
   end

   // pads: the external clock owns them only while in use
   assign diffOn = extOutUsed & extDiffMode;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pinPOut_ff <= 1'b0;
         pinPOe_ff  <= 1'b0;
         pinNOut_ff <= 1'b0;
         pinNOe_ff  <= 1'b0;
      end else begin
         pinPOut_ff <= extOutUsed ? postLvl_ff[poc_pkg::IDX_EXT] : gpioPOut;
         pinPOe_ff  <= extOutUsed | gpioPOe;
         pinNOut_ff <= diffOn ? ~postLvl_ff[poc_pkg::IDX_EXT] : gpioNOut;
         pinNOe_ff  <= diffOn | gpioNOe;
      end
   end

   assign globalClkA = postLvl_ff[poc_pkg::IDX_GA];
   assign globalClkB = postLvl_ff[poc_pkg::IDX_GB];
   assign extPinPOut = pinPOut_ff;
   assign extPinPOe  = pinPOe_ff;
   assign extPinNOut = pinNOut_ff;
   assign extPinNOe  = pinNOe_ff;
   assign gpioPIn    = sync_ff[poc_pkg::S_PADP];
   assign gpioNIn    = sync_ff[poc_pkg::S_PADN];
   assign pllLocked  = (lockState_ff == poc_pkg::LK_HOLD);
endmodule : poc_pll_core
